// File: rtl/lowpower_wake_config.v
/*
  low-power mode control: serial register access to the timing config and
  wake-enable words, periodic wake timer, polling timer and switch wake.
  assumes serial pins and switch levels are asynchronous to sys_clk_i and
  that the serial clock is at most a tenth of the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lowpower_wake_regs.vh"

module lowpower_wake_config #(
  parameter CYC_PER_MS = `CYC_PER_MS,
  parameter ACT_POLL_SG_CYC = `ACT_POLL_CYC,
  parameter ACT_POLL_SB_CYC = `ACT_POLL_CYC,
  parameter NUM_PROG = 12
) (
  // clock, reset, enable
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  // serial link pins
  input wire sclk_i,
  input wire cs_n_i,
  input wire mosi_i,
  output reg miso_o,
  output reg miso_oe_n_o,
  // device state
  input wire lpm_request_i,
  input wire fault_i,
  input wire ground_wake_all_off_i,
  input wire ground_wake_event_i,
  input wire [NUM_PROG-1:0] switch_state_i,
  // outputs
  output reg low_power_mode_o,
  output wire irq_n_o,
  output reg ground_poll_on_o,
  output reg battery_poll_on_o,
  output wire [3:0] poll_code_o,
  output wire [NUM_PROG-1:0] prog_input_wake_bits_o
);

  // ==========================================================
  // code tables
  function [9:0] int_ms;
    input [3:0] code;
    begin
      case (code)
        4'h1: int_ms = 10'd6;
        4'h2: int_ms = 10'd12;
        4'h3: int_ms = 10'd24;
        4'h4: int_ms = 10'd48;
        4'h5: int_ms = 10'd96;
        4'h6: int_ms = 10'd192;
        4'h7: int_ms = 10'd394;
        4'h8: int_ms = 10'd4;
        4'h9: int_ms = 10'd8;
        4'ha: int_ms = 10'd16;
        4'hb: int_ms = 10'd32;
        4'hc: int_ms = 10'd64;
        4'hd: int_ms = 10'd128;
        4'he: int_ms = 10'd256;
        4'hf: int_ms = 10'd512;
        default: int_ms = 10'd0;
      endcase
    end
  endfunction

  function [9:0] poll_ms;
    input [3:0] code;
    begin
      case (code)
        4'h0: poll_ms = 10'd3;
        4'h1: poll_ms = 10'd6;
        4'h2: poll_ms = 10'd12;
        4'h3: poll_ms = 10'd24;
        4'h4: poll_ms = 10'd48;
        4'h5: poll_ms = 10'd68;
        4'h6: poll_ms = 10'd76;
        4'h7: poll_ms = 10'd128;
        4'h8: poll_ms = 10'd32;
        4'h9: poll_ms = 10'd36;
        4'ha: poll_ms = 10'd40;
        4'hb: poll_ms = 10'd44;
        4'hc: poll_ms = 10'd52;
        4'hd: poll_ms = 10'd56;
        4'he: poll_ms = 10'd60;
        default: poll_ms = 10'd64;
      endcase
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  reg [2:0] sclk_sync_reg;
  reg [1:0] cs_sync_reg;
  reg cs_last_reg;
  reg [1:0] mosi_sync_reg;
  reg [NUM_PROG-1:0] sw_meta_reg;
  reg [NUM_PROG-1:0] sw_sync_reg;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_fall;
  wire cs_rise;

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sclk_sync_reg <= 3'b000;
      cs_sync_reg <= 2'b11;
      cs_last_reg <= 1'b1;
      mosi_sync_reg <= 2'b00;
      sw_meta_reg <= {NUM_PROG{1'b0}};
      sw_sync_reg <= {NUM_PROG{1'b0}};
    end else if (ce_i) begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
      cs_sync_reg <= {cs_sync_reg[0], cs_n_i};
      cs_last_reg <= cs_sync_reg[1];
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_i};
      sw_meta_reg <= switch_state_i;
      sw_sync_reg <= sw_meta_reg;
    end
  end

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2] & ~cs_sync_reg[1];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2] & ~cs_sync_reg[1];
  assign cs_fall = ~cs_sync_reg[1] & cs_last_reg;
  assign cs_rise = cs_sync_reg[1] & ~cs_last_reg;

  // ==========================================================
  // registers and flags
  reg [7:0] timing_cfg_reg;
  reg [NUM_PROG-1:0] wake_bits_reg;
  reg irq_pending_reg;
  reg [6:0] resp_addr_reg;
  reg resp_rw_reg;
  reg [`FRAME_BITS-1:0] rx_shift_reg;
  reg [`FRAME_BITS-1:0] tx_shift_reg;
  reg [`FRAME_CNT_W-1:0] bit_cnt_reg;
  reg [NUM_PROG-1:0] sw_ref_reg;
  reg [15:0] sg_poll_cnt_reg;
  reg [15:0] sb_poll_cnt_reg;
  reg [`DATA_W-1:0] resp_data;
  reg [`DATA_W-1:0] reg_data;
  wire frame_done;
  wire [6:0] rx_addr;
  wire timer_wake;
  wire poll_event;
  wire switch_wake;
  wire any_wake_enabled;

  assign rx_addr = rx_shift_reg[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
  assign frame_done = cs_rise && (bit_cnt_reg == `FRAME_BITS);
  assign poll_code_o = timing_cfg_reg[`POLL_CODE_HI:`POLL_CODE_LO];
  assign prog_input_wake_bits_o = wake_bits_reg;
  assign irq_n_o = ~irq_pending_reg;

  // read data, unused bits zero, flags live
  always @* begin
    reg_data = {`DATA_W{1'b0}};
    case (resp_addr_reg)
      `ADDR_LOWPOWER_TIMING_CONFIG: reg_data[7:0] = timing_cfg_reg;
      `ADDR_PROG_INPUT_WAKE_ENABLE: reg_data[NUM_PROG-1:0] = wake_bits_reg;
      default: reg_data = {`DATA_W{1'b0}};
    endcase
    resp_data = reg_data;
    resp_data[`FAULT_BIT] = fault_i;
    resp_data[`IRQ_PENDING_BIT] = irq_pending_reg;
  end

  // ==========================================================
  // serial shifter and register writes
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rx_shift_reg <= {`FRAME_BITS{1'b0}};
      tx_shift_reg <= {`FRAME_BITS{1'b0}};
      bit_cnt_reg <= {`FRAME_CNT_W{1'b0}};
      resp_addr_reg <= 7'h00;
      resp_rw_reg <= 1'b0;
      miso_o <= 1'b0;
      miso_oe_n_o <= 1'b1;
      timing_cfg_reg <= `LOWPOWER_TIMING_RESET;
      wake_bits_reg <= `PROG_WAKE_RESET;
    end else if (ce_i) begin
      if (cs_fall) begin
        tx_shift_reg <= {resp_addr_reg, resp_rw_reg, resp_data};
        miso_o <= resp_addr_reg[6];
        miso_oe_n_o <= 1'b0;
        bit_cnt_reg <= {`FRAME_CNT_W{1'b0}};
      end else if (cs_rise) begin
        miso_oe_n_o <= 1'b1;
      end
      if (sclk_rise) begin
        rx_shift_reg <= {rx_shift_reg[`FRAME_BITS-2:0], mosi_sync_reg[1]};
        if (bit_cnt_reg != 6'd63) begin
          bit_cnt_reg <= bit_cnt_reg + 6'd1;
        end
      end
      if (sclk_fall) begin
        tx_shift_reg <= {tx_shift_reg[`FRAME_BITS-2:0], 1'b0};
        miso_o <= tx_shift_reg[`FRAME_BITS-2];
      end
      // short or long frames are dropped whole
      if (frame_done) begin
        resp_addr_reg <= rx_addr;
        resp_rw_reg <= rx_shift_reg[`FRAME_RW_BIT];
        if (rx_shift_reg[`FRAME_RW_BIT] && !low_power_mode_o) begin
          if (rx_addr == `ADDR_LOWPOWER_TIMING_CONFIG) begin
            timing_cfg_reg <= rx_shift_reg[7:0];
          end
          if (rx_addr == `ADDR_PROG_INPUT_WAKE_ENABLE) begin
            wake_bits_reg <= rx_shift_reg[NUM_PROG-1:0];
          end
        end
      end
    end
  end

  // ==========================================================
  // low-power mode and interrupt flag
  assign switch_wake = |((sw_sync_reg ^ sw_ref_reg) & wake_bits_reg);
  assign any_wake_enabled = (|wake_bits_reg) | ~ground_wake_all_off_i;

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      low_power_mode_o <= 1'b0;
      irq_pending_reg <= 1'b0;
      sw_ref_reg <= {NUM_PROG{1'b0}};
    end else if (ce_i) begin
      if (!low_power_mode_o) begin
        sw_ref_reg <= sw_sync_reg;
        if (lpm_request_i) begin
          low_power_mode_o <= 1'b1;
        end
      end else if (timer_wake || switch_wake || ground_wake_event_i) begin
        low_power_mode_o <= 1'b0;
      end
      // a new event in the frame_done cycle keeps the flag set
      if (low_power_mode_o && (timer_wake || switch_wake || ground_wake_event_i)) begin
        irq_pending_reg <= 1'b1;
      end else if (frame_done) begin
        irq_pending_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // timers
  lp_interval_timer #(
    .CYC_PER_MS(CYC_PER_MS),
    .PRE_W(32),
    .MS_W(10)
  ) irq_timer (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .run_i(low_power_mode_o && (timing_cfg_reg[`INT_CODE_HI:`INT_CODE_LO] != 4'h0)),
    .period_ms_i(int_ms(timing_cfg_reg[`INT_CODE_HI:`INT_CODE_LO])),
    .expire_o(timer_wake)
  );

  lp_interval_timer #(
    .CYC_PER_MS(CYC_PER_MS),
    .PRE_W(32),
    .MS_W(10)
  ) poll_timer (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .run_i(low_power_mode_o && any_wake_enabled),
    .period_ms_i(poll_ms(poll_code_o)),
    .expire_o(poll_event)
  );

  // ==========================================================
  // active polling windows
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sg_poll_cnt_reg <= 16'h0000;
      sb_poll_cnt_reg <= 16'h0000;
      ground_poll_on_o <= 1'b0;
      battery_poll_on_o <= 1'b0;
    end else if (ce_i) begin
      if (poll_event) begin
        sg_poll_cnt_reg <= ACT_POLL_SG_CYC[15:0];
        sb_poll_cnt_reg <= ACT_POLL_SB_CYC[15:0];
        ground_poll_on_o <= 1'b1;
        battery_poll_on_o <= 1'b1;
      end else begin
        if (sg_poll_cnt_reg > 16'h0001) begin
          sg_poll_cnt_reg <= sg_poll_cnt_reg - 16'h0001;
        end else begin
          sg_poll_cnt_reg <= 16'h0000;
          ground_poll_on_o <= 1'b0;
        end
        if (sb_poll_cnt_reg > 16'h0001) begin
          sb_poll_cnt_reg <= sb_poll_cnt_reg - 16'h0001;
        end else begin
          sb_poll_cnt_reg <= 16'h0000;
          battery_poll_on_o <= 1'b0;
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: include/lowpower_wake_regs.vh
/*
  register map, field positions, reset values and timing counts of the
  low-power wake configuration block. assumes a 100 MHz system clock.
*/
`ifndef LOWPOWER_WAKE_REGS_VH
`define LOWPOWER_WAKE_REGS_VH

// ==========================================================
// frame layout
`define FRAME_BITS 32
`define FRAME_CNT_W 6
`define FRAME_ADDR_HI 31
`define FRAME_ADDR_LO 25
`define FRAME_RW_BIT 24
`define DATA_W 24

// ==========================================================
// register addresses
`define ADDR_LOWPOWER_TIMING_CONFIG 7'h0f
`define ADDR_PROG_INPUT_WAKE_ENABLE 7'h10

// ==========================================================
// fields
`define FAULT_BIT 23
`define IRQ_PENDING_BIT 22
`define INT_CODE_HI 7
`define INT_CODE_LO 4
`define POLL_CODE_HI 3
`define POLL_CODE_LO 0
`define WAKE_BITS_HI 11
`define WAKE_BITS_LO 0

// ==========================================================
// reset values
`define LOWPOWER_TIMING_RESET 8'h0f
`define PROG_WAKE_RESET 12'h0fff

// ==========================================================
// timing
`define SYS_CLK_NS 10
`define MS_NS 1000000
`define CYC_PER_MS (`MS_NS / `SYS_CLK_NS)
`define ACT_POLL_NS 50000
`define ACT_POLL_CYC (`ACT_POLL_NS / `SYS_CLK_NS)

`endif

// File: rtl/lp_interval_timer.v
/*
  millisecond interval timer: prescales the system clock to 1 ms ticks and
  pulses when the programmed number of milliseconds has elapsed.
  assumes the caller holds run_i low whenever the timer must stand still.
*/
`timescale 1ns/1ps
`default_nettype none

module lp_interval_timer #(
  parameter CYC_PER_MS = 100000,
  parameter PRE_W = 17,
  parameter MS_W = 10
) (
  // clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  // control
  input wire run_i,
  input wire [MS_W-1:0] period_ms_i,
  // event
  output reg expire_o
);

  reg [PRE_W-1:0] pre_reg;
  reg [MS_W-1:0] ms_reg;
  wire ms_tick;

  assign ms_tick = (pre_reg == CYC_PER_MS[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1});

  // ==========================================================
  // counting
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pre_reg <= {PRE_W{1'b0}};
      ms_reg <= {MS_W{1'b0}};
      expire_o <= 1'b0;
    end else if (ce_i) begin
      expire_o <= 1'b0;
      if (!run_i) begin
        // restart from zero so each run gives a full period
        pre_reg <= {PRE_W{1'b0}};
        ms_reg <= {MS_W{1'b0}};
      end else if (ms_tick) begin
        pre_reg <= {PRE_W{1'b0}};
        if (ms_reg + {{(MS_W-1){1'b0}}, 1'b1} >= period_ms_i) begin
          ms_reg <= {MS_W{1'b0}};
          expire_o <= 1'b1;
        end else begin
          ms_reg <= ms_reg + {{(MS_W-1){1'b0}}, 1'b1};
        end
      end else begin
        pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// File: bench/lowpower_wake_config_monitor.sv
/*
  checker for lowpower_wake_config, bound from the bench.
  assumes ce_i stays high and reset is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module lowpower_wake_config_monitor #(
  parameter NUM_PROG = 12,
  parameter ACT_POLL_SG_CYC = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // watched ports
  input wire logic cs_n_i,
  input wire logic ground_wake_all_off_i,
  input wire logic miso_oe_n_o,
  input wire logic low_power_mode_o,
  input wire logic irq_n_o,
  input wire logic ground_poll_on_o,
  input wire logic [3:0] poll_code_o,
  input wire logic [NUM_PROG-1:0] prog_input_wake_bits_o
);
  // ==========
  // properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  int wcnt_reg;
  always @(posedge sys_clk_i) begin
    if (sys_rst_i || !ground_poll_on_o) wcnt_reg <= 0;
    else wcnt_reg <= wcnt_reg + 1;
  end
  a_irq_from_lpm: assert property (
    $fell(irq_n_o) |-> $past(low_power_mode_o) || $past(low_power_mode_o, 2))
    else $error("irq outside low power");
  a_irq_holds: assert property (
    cs_n_i[*8] ##0 !irq_n_o |=> !irq_n_o) else $error("irq lost without frame");
  a_oe_idle: assert property (
    cs_n_i[*6] |-> miso_oe_n_o) else $error("miso driven while idle");
  a_cfg_stable: assert property (
    $changed(poll_code_o) |-> cs_n_i && !low_power_mode_o) else $error("poll code moved");
  a_wake_stable: assert property (
    $changed(prog_input_wake_bits_o) |-> cs_n_i && !low_power_mode_o)
    else $error("wake bits moved");
  // a poll event on the last low-power cycle may open its window after wake
  a_poll_in_lpm: assert property (
    $rose(ground_poll_on_o) |-> $past(low_power_mode_o, 2)) else $error("poll in normal mode");
  a_poll_stopped: assert property (
    $rose(ground_poll_on_o) |-> !$past(ground_wake_all_off_i)
      || $past(prog_input_wake_bits_o) != 0) else $error("poll with all wake off");
  a_poll_width: assert property (
    $fell(ground_poll_on_o) |-> wcnt_reg == ACT_POLL_SG_CYC) else $error("poll width");
endmodule
`default_nettype wire

// File: bench/spi_host.sv
/*
  host side of the serial link: sends 32-bit frames msb first.
  assumes clk is the bench clock; sclk stands low between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  // bench clock
  input wire logic clk,
  // serial pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // ==========
  // frame task
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // hp is the sclk half period in clk cycles; 8 or more
  task automatic xfer(input logic [31:0] w, input int hp, output logic [31:0] r);
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi = w[i];
      repeat (hp) @(negedge clk);
      r[i] = miso;
      sclk = 1'b1;
      repeat (hp) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (hp) @(negedge clk);
    cs_n = 1'b1;
    // released line must not keep the last bit
    mosi = ~mosi;
    repeat (hp) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
/*
  bench for lowpower_wake_config: register frames and low-power timing.
  assumes the register header is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lowpower_wake_regs.vh"
module tb;
  // ==========
  // signals
  localparam int CPM = 10;
  localparam logic [6:0] CFG = `ADDR_LOWPOWER_TIMING_CONFIG;
  localparam logic [6:0] WK = `ADDR_PROG_INPUT_WAKE_ENABLE;
  int int_ms[16] = '{0, 6, 12, 24, 48, 96, 192, 394, 4, 8, 16, 32, 64, 128, 256, 512};
  int poll_ms[16] = '{3, 6, 12, 24, 48, 68, 76, 128, 32, 36, 40, 44, 52, 56, 60, 64};
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic lpm_request_i = 1'b0;
  logic fault_i = 1'b0;
  logic ground_wake_all_off_i = 1'b0;
  logic [11:0] switch_state_i = 12'h0000;
  wire logic sclk, cs_n, mosi, miso, miso_oe_n, low_power_mode, irq_n, gpoll, bpoll;
  wire logic [3:0] poll_code;
  wire logic [11:0] wake_bits;
  wire logic miso_w = miso_oe_n ? ~miso : miso;
  logic [31:0] r;
  int errors = 0;
  int checked = 0;
  int rises = 0;
  int cyc = 0;
  int n, t1, t2;
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) cyc++;
  always @(posedge gpoll) rises++;
  lowpower_wake_config #(.CYC_PER_MS(CPM), .ACT_POLL_SG_CYC(3), .ACT_POLL_SB_CYC(3))
  u_lowpower_wake_config (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(miso_oe_n),
    .lpm_request_i(lpm_request_i), .fault_i(fault_i),
    .ground_wake_all_off_i(ground_wake_all_off_i), .ground_wake_event_i(1'b0),
    .switch_state_i(switch_state_i), .low_power_mode_o(low_power_mode), .irq_n_o(irq_n),
    .ground_poll_on_o(gpoll), .battery_poll_on_o(bpoll), .poll_code_o(poll_code),
    .prog_input_wake_bits_o(wake_bits));
  spi_host u_spi_host (.clk(sys_clk_i), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic [6:0] a, input logic w, input logic [23:0] d);
    u_spi_host.xfer({a, w, d}, 8, r);
  endtask
  task automatic enter;
    @(negedge sys_clk_i);
    lpm_request_i = 1'b1;
    @(negedge sys_clk_i);
    lpm_request_i = 1'b0;
  endtask
  task automatic wait_wake(input int lim, output int k);
    k = 0;
    while (low_power_mode === 1'b1 && k < lim) begin
      @(negedge sys_clk_i);
      k++;
    end
  endtask
  task automatic next_poll(output int t);
    int k0;
    k0 = rises;
    t = 0;
    while (rises == k0 && t < 3000) begin
      @(negedge sys_clk_i);
      t++;
    end
    t = cyc;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    #950_000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk({wake_bits, poll_code, irq_n, low_power_mode}, 18'h3_fffe);
    xf(CFG, 1'b0, 24'h00_0000);
    xf(WK, 1'b0, 24'h00_0000);
    chk(r, {CFG, 1'b0, 24'h00_000f});
    xf(CFG, 1'b1, 24'hff_ff81);
    chk(r, {WK, 1'b0, 24'h00_0fff});
    xf(WK, 1'b1, 24'hff_f001);
    chk(r, {CFG, 1'b1, 24'h00_0081});
    fault_i = 1'b1;
    xf(WK, 1'b0, 24'h00_0000);
    chk(r, {WK, 1'b1, 24'h80_0001});
    fault_i = 1'b0;
    xf(CFG, 1'b0, 24'h00_0000);
    chk(r, {WK, 1'b0, 24'h00_0001});
    chk({wake_bits, poll_code}, 16'h0011);
    $display("test registers done");
    for (int c = 1; c < 16; c++) begin
      xf(CFG, 1'b1, {16'h0000, c[3:0], 4'h0});
      chk(r[22], c > 1);
      chk(irq_n, 1'b1);
      enter();
      wait_wake(6000, n);
      chk(n >= int_ms[c] * CPM && n <= int_ms[c] * CPM + 3, 1);
      chk(irq_n, 1'b0);
    end
    ground_wake_all_off_i = 1'b1;
    xf(WK, 1'b1, 24'h00_0000);
    xf(CFG, 1'b1, 24'h00_0080);
    t1 = rises;
    enter();
    wait_wake(6000, n);
    chk(n >= 4 * CPM && n <= 4 * CPM + 3, 1);
    chk(rises - t1, 0);
    ground_wake_all_off_i = 1'b0;
    xf(WK, 1'b1, 24'h00_0001);
    $display("test wake timer done");
    for (int p = 0; p < 16; p++) begin
      xf(CFG, 1'b1, {20'h0_0000, p[3:0]});
      enter();
      next_poll(t1);
      next_poll(t2);
      chk(t2 - t1, poll_ms[p] * CPM);
      chk({gpoll, bpoll}, 2'b11);
      switch_state_i[1] = ~switch_state_i[1];
      repeat (10) @(negedge sys_clk_i);
      chk(low_power_mode, 1'b1);
      switch_state_i[0] = ~switch_state_i[0];
      wait_wake(10, n);
      chk(low_power_mode, 1'b0);
    end
    $display("test polling done");
    print_verdict();
  end
endmodule
bind lowpower_wake_config lowpower_wake_config_monitor #(
  .NUM_PROG(NUM_PROG), .ACT_POLL_SG_CYC(ACT_POLL_SG_CYC)) u_mon (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i),
  .ground_wake_all_off_i(ground_wake_all_off_i), .miso_oe_n_o(miso_oe_n_o),
  .low_power_mode_o(low_power_mode_o), .irq_n_o(irq_n_o),
  .ground_poll_on_o(ground_poll_on_o), .poll_code_o(poll_code_o),
  .prog_input_wake_bits_o(prog_input_wake_bits_o));
`default_nettype wire
